// *** design/dram_req_pkg.sv ***
// Shared constants and types for the user request port of the DRAM controller.
// ****************************************************************************
// Summary of operation
// R1 - Command enable high marks command inputs valid.
// R2 - Slot code: 00 write, 01 read, 1x no-op.
// R3 - No-op slots skipped; other slots executed.
// R4 - Single-slot configuration: user never sends no-op.
// R5 - Build-time constant fixes commands per fabric cycle.
// R6 - One address per slot, taken under command enable.
// R7 - One bank per slot, taken under command enable.
// R8 - Write enable qualifies data and mask, independently.
// R9 - Write data is rise and fall halves concatenated.
// R10 - Active-high primary reset holds controller in reset.
// R11 - Core runs from differential primary clock pair; the code clocks from clk only, clkN is unused.
// R12 - Writes into a full buffer are discarded.
// R13 - User never mixes read and write in one word.
// R14 - Slots serviced in order; reads return in order.
// R15 - Calibration done is signalled; requests follow it.
// R16 - Inputs sampled on rising edge, only when enabled.
// ****************************************************************************
`default_nettype none
package dram_req_pkg;

  // Geometry of the request word.
  localparam int MEM_CLK_PER_FABRIC = 4;
  localparam int BURST_LENGTH       = 2;
  localparam int CMD_PER_CLK        = 2 * MEM_CLK_PER_FABRIC / BURST_LENGTH; // [R5]
  localparam int SLOT_WIDTH         = 2;
  localparam int CMD_WIDTH          = 2;
  localparam int ADDR_WIDTH         = 20;
  localparam int BANK_WIDTH         = 4;
  localparam int DATA_WIDTH         = 18;
  localparam int DM_WIDTH           = 2;
  localparam int WR_DATA_WIDTH      = 2 * MEM_CLK_PER_FABRIC * DATA_WIDTH; // [R9]
  localparam int WR_MASK_WIDTH      = 2 * MEM_CLK_PER_FABRIC * DM_WIDTH;

  // Buffer sizing.
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_WIDTH  = 2;
  localparam int CNT_WIDTH  = 3;
  localparam logic [CNT_WIDTH-1:0] CNT_FULL   = 3'h4;
  localparam logic [CNT_WIDTH-1:0] CNT_AFULL  = 3'h3;
  localparam logic [CNT_WIDTH-1:0] CNT_AEMPTY = 3'h1;

  // Slot command codes; bit 1 set means no operation.
  typedef logic [CMD_WIDTH-1:0] cmd_t;
  localparam cmd_t CMD_WRITE = 2'h0;
  localparam cmd_t CMD_READ  = 2'h1;
  localparam cmd_t CMD_NOP_A = 2'h2;
  localparam cmd_t CMD_NOP_B = 2'h3;
  localparam int   NOP_BIT   = 1;

  // Reset pipeline length for rst_n; the sysRst pipeline has two fixed stages.
  localparam int RST_STAGES = 2;

  // One buffered command word, all slots together.
  typedef struct packed {
    logic [CMD_PER_CLK-1:0][CMD_WIDTH-1:0]  cmd;
    logic [CMD_PER_CLK-1:0][ADDR_WIDTH-1:0] addr;
    logic [CMD_PER_CLK-1:0][BANK_WIDTH-1:0] bank;
  } cmd_word_s;

  // One buffered write beat.
  typedef struct packed {
    logic [WR_DATA_WIDTH-1:0] data;
    logic [WR_MASK_WIDTH-1:0] mask;
  } wr_beat_s;

  // Slot walker states, one-hot.
  typedef enum logic [1:0] {
    WALK_IDLE = 2'h1,
    WALK_BUSY = 2'h2
  } walk_e;

endpackage : dram_req_pkg
`default_nettype wire

// *** design/dram_user_request_port.sv ***
// User request port: buffers command words and write beats for the DRAM controller.
`timescale 1ns/1ns
`default_nettype none
module dram_user_request_port (
  // Primary clock pair and resets.
  input  wire logic                                  clk,
  input  wire logic                                  clkN,
  input  wire logic                                  rst_n,
  input  wire logic                                  sysRst,
  // Command request channel.
  input  wire logic                                  cmdEn,
  input  wire logic [2*dram_req_pkg::CMD_PER_CLK-1:0] cmd,
  input  wire logic [dram_req_pkg::CMD_PER_CLK*dram_req_pkg::ADDR_WIDTH-1:0] addr,
  input  wire logic [dram_req_pkg::CMD_PER_CLK*dram_req_pkg::BANK_WIDTH-1:0] bank,
  // Write data channel.
  input  wire logic                                  wrEn,
  input  wire logic [dram_req_pkg::WR_DATA_WIDTH-1:0] wrData,
  input  wire logic [dram_req_pkg::WR_MASK_WIDTH-1:0] wrMask,
  // Buffer status.
  output logic                                       cmdBufEmpty,
  output logic                                       cmdBufAlmostEmpty,
  output logic                                       cmdBufAlmostFull,
  output logic                                       cmdBufFull,
  output logic                                       wrBufEmpty,
  output logic                                       wrBufAlmostEmpty,
  output logic                                       wrBufAlmostFull,
  output logic                                       wrBufFull,
  output logic                                       cmdDropped,
  output logic                                       wrDropped,
  // Calibration.
  input  wire logic                                  calibDoneIn,
  output logic                                       calibComplete,
  // Memory-side command stream.
  input  wire logic                                  memCmdReady,
  output logic                                       memCmdValid,
  output logic                                       memCmdWrite,
  output logic [dram_req_pkg::ADDR_WIDTH-1:0]        memCmdAddr,
  output logic [dram_req_pkg::BANK_WIDTH-1:0]        memCmdBank,
  output logic [dram_req_pkg::SLOT_WIDTH-1:0]        memCmdSlot,
  // Memory-side write beat stream.
  input  wire logic                                  memWrReady,
  output logic                                       memWrValid,
  output logic [dram_req_pkg::WR_DATA_WIDTH-1:0]     memWrData,
  output logic [dram_req_pkg::WR_MASK_WIDTH-1:0]     memWrMask
);

  // ****************************************************************************
  // State
  // ****************************************************************************

  typedef struct packed {
    logic                                               sysRstMeta;
    logic                                               sysRstSync;
    logic                                               calibDone;
    dram_req_pkg::cmd_word_s [dram_req_pkg::FIFO_DEPTH-1:0] cmdMem;
    logic [dram_req_pkg::PTR_WIDTH-1:0]                 cmdWrPtr;
    logic [dram_req_pkg::PTR_WIDTH-1:0]                 cmdRdPtr;
    logic [dram_req_pkg::CNT_WIDTH-1:0]                 cmdCnt;
    dram_req_pkg::wr_beat_s [dram_req_pkg::FIFO_DEPTH-1:0] wrMem;
    logic [dram_req_pkg::PTR_WIDTH-1:0]                 wrWrPtr;
    logic [dram_req_pkg::PTR_WIDTH-1:0]                 wrRdPtr;
    logic [dram_req_pkg::CNT_WIDTH-1:0]                 wrCnt;
    logic                                               cmdDrop;
    logic                                               wrDrop;
  } port_s;

  localparam port_s PORT_RESET = '0;

  port_s                                 st_r;
  port_s                                 st_nxt;
  logic [dram_req_pkg::RST_STAGES-1:0]   rstPipe_r;
  logic                                  rstSyncN;
  logic                                  cmdPush;
  logic                                  cmdPop;
  logic                                  wrPush;
  logic                                  wrPop;
  dram_req_pkg::cmd_word_s               inWord;

  slot_if slots ();

  // ****************************************************************************
  // Reset release
  // ****************************************************************************

  // The complement clock leg clkN drives no logic inside this module, so
  // only the true leg clocks the logic; clkN is kept for pin compatibility.
  // [R11]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= '0;
    end else begin
      rstPipe_r <= {rstPipe_r[dram_req_pkg::RST_STAGES-2:0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe_r[dram_req_pkg::RST_STAGES-1];

  // ****************************************************************************
  // Buffer control
  // ****************************************************************************

  // Flat user buses map slot by slot into one word; slot 0 in the low bits.
  assign inWord = '{cmd: cmd, addr: addr, bank: bank}; // [R6] [R7]

  // Requests are taken only on an enabled edge, with room, after calibration.
  // Refusing early requests avoids feeding the walker before the PHY is trained.
  assign cmdPush = cmdEn && (st_r.cmdCnt != dram_req_pkg::CNT_FULL)
                   && st_r.calibDone && !st_r.sysRstSync;             // [R1] [R12] [R16]
  assign wrPush  = wrEn && (st_r.wrCnt != dram_req_pkg::CNT_FULL)
                   && st_r.calibDone && !st_r.sysRstSync;             // [R8] [R12] [R16]
  assign cmdPop  = slots.wordTaken;
  assign wrPop   = memWrValid && memWrReady;

  // Next state of both buffers, the reset pipeline and the calibration flag.
  always_comb begin
    st_nxt            = st_r;
    st_nxt.sysRstMeta = sysRst;
    st_nxt.sysRstSync = st_r.sysRstMeta;
    st_nxt.calibDone  = calibDoneIn; // [R15]
    st_nxt.cmdDrop    = cmdEn && !cmdPush; // [R12]
    st_nxt.wrDrop     = wrEn && !wrPush;   // [R12]
    if (cmdPush) begin
      st_nxt.cmdMem[st_r.cmdWrPtr] = inWord;
      st_nxt.cmdWrPtr              = st_r.cmdWrPtr + 1'b1;
    end
    if (cmdPop) begin
      st_nxt.cmdRdPtr = st_r.cmdRdPtr + 1'b1; // Words leave in arrival order. [R14]
    end
    unique case ({cmdPush, cmdPop})
      2'h2:    st_nxt.cmdCnt = st_r.cmdCnt + 1'b1;
      2'h1:    st_nxt.cmdCnt = st_r.cmdCnt - 1'b1;
      default: st_nxt.cmdCnt = st_r.cmdCnt;
    endcase
    if (wrPush) begin
      st_nxt.wrMem[st_r.wrWrPtr] = '{data: wrData, mask: wrMask}; // [R8] [R9]
      st_nxt.wrWrPtr             = st_r.wrWrPtr + 1'b1;
    end
    if (wrPop) begin
      st_nxt.wrRdPtr = st_r.wrRdPtr + 1'b1;
    end
    unique case ({wrPush, wrPop})
      2'h2:    st_nxt.wrCnt = st_r.wrCnt + 1'b1;
      2'h1:    st_nxt.wrCnt = st_r.wrCnt - 1'b1;
      default: st_nxt.wrCnt = st_r.wrCnt;
    endcase
    // The primary reset clears everything but its own pipeline.
    if (st_r.sysRstSync) begin
      st_nxt            = PORT_RESET; // [R10]
      st_nxt.sysRstMeta = sysRst;
      st_nxt.sysRstSync = st_r.sysRstMeta;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_r <= PORT_RESET;
    end else begin
      st_r <= st_nxt; // [R16]
    end
  end

  // ****************************************************************************
  // Slot issue
  // ****************************************************************************

  assign slots.wordValid = (st_r.cmdCnt != '0);
  assign slots.word      = st_r.cmdMem[st_r.cmdRdPtr];

  slot_walker u_walker (
    .clk         (clk),
    .rstN        (rstSyncN),
    .holdRst     (st_r.sysRstSync),
    .slots       (slots.walker),
    .memCmdReady (memCmdReady),
    .memCmdValid (memCmdValid),
    .memCmdWrite (memCmdWrite),
    .memCmdAddr  (memCmdAddr),
    .memCmdBank  (memCmdBank),
    .memCmdSlot  (memCmdSlot)
  );

  // ****************************************************************************
  // Outputs
  // ****************************************************************************

  // Status comes straight from the registered counts and flags.
  assign cmdBufEmpty       = (st_r.cmdCnt == '0);
  assign cmdBufAlmostEmpty = (st_r.cmdCnt <= dram_req_pkg::CNT_AEMPTY);
  assign cmdBufAlmostFull  = (st_r.cmdCnt >= dram_req_pkg::CNT_AFULL);
  assign cmdBufFull        = (st_r.cmdCnt == dram_req_pkg::CNT_FULL); // [R12]
  assign wrBufEmpty        = (st_r.wrCnt == '0);
  assign wrBufAlmostEmpty  = (st_r.wrCnt <= dram_req_pkg::CNT_AEMPTY);
  assign wrBufAlmostFull   = (st_r.wrCnt >= dram_req_pkg::CNT_AFULL);
  assign wrBufFull         = (st_r.wrCnt == dram_req_pkg::CNT_FULL);  // [R12]
  assign cmdDropped        = st_r.cmdDrop;
  assign wrDropped         = st_r.wrDrop;
  assign calibComplete     = st_r.calibDone; // [R15]

  // Write beats drain in order from the buffer head.
  assign memWrValid = (st_r.wrCnt != '0);
  assign memWrData  = st_r.wrMem[st_r.wrRdPtr].data;
  assign memWrMask  = st_r.wrMem[st_r.wrRdPtr].mask;

endmodule : dram_user_request_port
`default_nettype wire

// *** design/slot_if.sv ***
// Interface between the command buffer and the slot walker.
`timescale 1ns/1ns
`default_nettype none
interface slot_if;
  logic                   wordValid;
  dram_req_pkg::cmd_word_s word;
  logic                   wordTaken;

  modport feeder (output wordValid, output word, input wordTaken);
  modport walker (input wordValid, input word, output wordTaken);
endinterface : slot_if
`default_nettype wire

// *** design/slot_walker.sv ***
// Slot walker: issues the slots of one command word in order, skipping no-ops.
`timescale 1ns/1ns
`default_nettype none
module slot_walker (
  // Clock and reset.
  input  wire logic                                clk,
  input  wire logic                                rstN,
  input  wire logic                                holdRst,
  // Command words from the buffer.
  slot_if.walker                                   slots,
  // Memory-side command stream.
  input  wire logic                                memCmdReady,
  output logic                                     memCmdValid,
  output logic                                     memCmdWrite,
  output logic [dram_req_pkg::ADDR_WIDTH-1:0]      memCmdAddr,
  output logic [dram_req_pkg::BANK_WIDTH-1:0]      memCmdBank,
  output logic [dram_req_pkg::SLOT_WIDTH-1:0]      memCmdSlot
);

  typedef struct packed {
    dram_req_pkg::walk_e                     state;
    dram_req_pkg::cmd_word_s                 word;
    logic [dram_req_pkg::CMD_PER_CLK-1:0]    pending;
    logic                                    outValid;
    logic                                    outWrite;
    logic [dram_req_pkg::ADDR_WIDTH-1:0]     outAddr;
    logic [dram_req_pkg::BANK_WIDTH-1:0]     outBank;
    logic [dram_req_pkg::SLOT_WIDTH-1:0]     outSlot;
  } walk_s;

  localparam walk_s WALK_RESET = '{state: dram_req_pkg::WALK_IDLE, default: '0};

  walk_s                                 st_r;
  walk_s                                 st_nxt;
  logic [dram_req_pkg::CMD_PER_CLK-1:0]  isOp;

  // Mark the live slots of the word at the buffer head; no-op codes are dropped here.
  for (genvar s = 0; s < dram_req_pkg::CMD_PER_CLK; s++) begin : g_slot
    assign isOp[s] = ~slots.word.cmd[s][dram_req_pkg::NOP_BIT]; // [R2] [R3]
  end

  // A word is taken only when the walker has finished the previous one.
  assign slots.wordTaken = slots.wordValid && (st_r.state == dram_req_pkg::WALK_IDLE);

  // Next state: hold a stalled slot, else issue the lowest pending slot.
  always_comb begin
    logic                                  found;
    logic [dram_req_pkg::SLOT_WIDTH-1:0]   idx;
    found  = 1'b0;
    idx    = '0;
    st_nxt = st_r;
    for (int i = 0; i < dram_req_pkg::CMD_PER_CLK; i++) begin
      if (!found && st_r.pending[i]) begin
        found = 1'b1;
        idx   = dram_req_pkg::SLOT_WIDTH'(i); // Lowest first keeps slot order. [R14]
      end
    end
    if (!(st_r.outValid && !memCmdReady)) begin
      st_nxt.outValid = found;
      if (found) begin
        st_nxt.outWrite     = (st_r.word.cmd[idx] == dram_req_pkg::CMD_WRITE); // [R2]
        st_nxt.outAddr      = st_r.word.addr[idx];
        st_nxt.outBank      = st_r.word.bank[idx];
        st_nxt.outSlot      = idx;
        st_nxt.pending[idx] = 1'b0;
      end
    end
    unique case (st_r.state)
      dram_req_pkg::WALK_IDLE: begin
        if (slots.wordValid) begin
          st_nxt.word    = slots.word;
          st_nxt.pending = isOp; // [R3]
          st_nxt.state   = dram_req_pkg::WALK_BUSY;
        end
      end
      dram_req_pkg::WALK_BUSY: begin
        // The last pending slot moves to the output this cycle; accept the next word.
        if (st_nxt.pending == '0) begin
          st_nxt.state = dram_req_pkg::WALK_IDLE;
        end
      end
    endcase
    if (holdRst) begin
      st_nxt = WALK_RESET; // [R10]
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_r <= WALK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign memCmdValid = st_r.outValid;
  assign memCmdWrite = st_r.outWrite;
  assign memCmdAddr  = st_r.outAddr;
  assign memCmdBank  = st_r.outBank;
  assign memCmdSlot  = st_r.outSlot;

endmodule : slot_walker
`default_nettype wire

// *** tb/dram_user_request_port_assertions.sv ***
// Concurrent checks on the pins of the user request port.
`timescale 1ns/1ns
`default_nettype none
module dram_user_request_port_assertions (
  // Clock and resets.
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sysRst,
  // User requests and far-side handshakes.
  input wire logic       cmdEn,
  input wire logic [7:0] cmd,
  input wire logic       wrEn,
  input wire logic       calibDoneIn,
  input wire logic       memCmdReady,
  input wire logic       memWrReady,
  // Port responses.
  input wire logic       cmdBufEmpty,
  input wire logic       cmdBufFull,
  input wire logic       wrBufFull,
  input wire logic       cmdDropped,
  input wire logic       wrDropped,
  input wire logic       calibComplete,
  input wire logic       memCmdValid,
  input wire logic       memCmdWrite,
  input wire logic [1:0] memCmdSlot,
  input wire logic       memWrValid,
  input wire logic [143:0] memWrData
);
  // ************************************************************
  // Settle counter and properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] upCnt_r;
  // Both resets ripple through sync stages, so checks wait seven quiet cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) upCnt_r <= 3'h0;
    else if (sysRst) upCnt_r <= 3'h0;
    else if (upCnt_r != 3'h7) upCnt_r <= upCnt_r + 3'h1;
  end
  wire logic live = (upCnt_r == 3'h7);
  // A quiet idle cycle followed by a word whose first slot reads.
  sequence seqIdle;
    !cmdEn && cmdBufEmpty && !memCmdValid;
  endsequence
  sequence seqReadWord;
    live && cmdEn && cmd[1:0] == 2'h1 && calibComplete && !memCmdValid;
  endsequence
  // Buffer, walker and output stage each add one register, so slot 0 shows on the third edge.
  AST_FIRST_SLOT: assert property (seqIdle ##1 seqReadWord |-> ##3
    memCmdValid && !memCmdWrite && memCmdSlot == 2'h0) else $error("first slot late");
  AST_CMD_TAKEN: assert property (live && cmdEn && !cmdBufFull && calibComplete
    |=> !cmdBufEmpty) else $error("command word not taken");
  AST_CMD_DROP: assert property (live && cmdEn && (cmdBufFull || !calibComplete)
    |=> cmdDropped) else $error("refused word not flagged");
  AST_WR_TAKEN: assert property (live && wrEn && !wrBufFull && calibComplete
    |=> memWrValid) else $error("write beat not taken");
  AST_WR_DROP: assert property (live && wrEn && (wrBufFull || !calibComplete)
    |=> wrDropped) else $error("refused beat not flagged");
  AST_CMD_HOLD: assert property (live && memCmdValid && !memCmdReady |=>
    memCmdValid && $stable(memCmdSlot) && $stable(memCmdWrite)) else $error("slot moved");
  AST_WR_HOLD: assert property (live && memWrValid && !memWrReady |=>
    memWrValid && $stable(memWrData)) else $error("beat moved in stall");
  AST_SYS_RESET: assert property (sysRst [*5] |->
    cmdBufEmpty && !memCmdValid && !memWrValid) else $error("reset left state");
  AST_CALIB: assert property (live |-> calibComplete == $past(calibDoneIn))
    else $error("calibration flag not one cycle behind");
endmodule : dram_user_request_port_assertions
`default_nettype wire

// *** tb/dram_user_request_port_tb.sv ***
// Self-checking bench for the user request port.
`timescale 1ns/1ns
`default_nettype none
module dram_user_request_port_tb;
  // ************************************************************
  // Signals, stimulus and scoreboard
  // ************************************************************
  localparam int N = dram_req_pkg::CMD_PER_CLK;
  localparam int AW = dram_req_pkg::ADDR_WIDTH;
  localparam int BW = dram_req_pkg::BANK_WIDTH;
  logic clk = 1'b0, rst_n = 1'b0, sysRst = 1'b0, cmdEn = 1'b0, wrEn = 1'b0;
  logic [7:0] cmd = 8'h0;
  logic [79:0] addr = 80'h0;
  logic [15:0] bank = 16'h0, wrMask = 16'h0;
  logic [143:0] wrData = 144'h0, memWrData;
  logic cmdBufEmpty, cmdBufAlmostEmpty, cmdBufAlmostFull, cmdBufFull, wrBufEmpty;
  logic wrBufAlmostEmpty, wrBufAlmostFull, wrBufFull, cmdDropped, wrDropped;
  logic calibDoneIn, calibComplete, memCmdReady, memCmdValid, memCmdWrite;
  logic memWrReady, memWrValid, inRst = 1'b0, stallAll = 1'b1, calibGo = 1'b0;
  logic [19:0] memCmdAddr;
  logic [3:0] memCmdBank;
  logic [1:0] memCmdSlot;
  logic [15:0] memWrMask;
  wire logic [26:0] slotSeen = {memCmdWrite, memCmdAddr, memCmdBank, memCmdSlot};
  wire logic clkN = ~clk;
  logic [26:0] cmdQ[$];
  logic [159:0] wrQ[$];
  integer seed = 32'hd659b5c0;
  int nMismatch = 0, totalChecks = 0, cycles = 0;
  dram_user_request_port dram_user_request_port_inst (.clk, .clkN, .rst_n, .sysRst, .cmdEn,
    .cmd, .addr, .bank, .wrEn, .wrData, .wrMask, .cmdBufEmpty, .cmdBufAlmostEmpty,
    .cmdBufAlmostFull, .cmdBufFull, .wrBufEmpty, .wrBufAlmostEmpty, .wrBufAlmostFull,
    .wrBufFull, .cmdDropped, .wrDropped, .calibDoneIn, .calibComplete, .memCmdReady,
    .memCmdValid, .memCmdWrite, .memCmdAddr, .memCmdBank, .memCmdSlot, .memWrReady,
    .memWrValid, .memWrData, .memWrMask);
  mem_side_model mem_side_model_inst (.clk, .stallAll, .calibGo, .memCmdReady,
    .memWrReady, .calibDoneIn);
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] got);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Random slot codes; one word never mixes reads with writes.
  function automatic logic [7:0] word(input logic [31:0] x);
    for (int s = 0; s < N; s++) word[2*s+:2] = {x[s], x[4]};
    if (N == 1) word[1] = 1'b0; // A single-slot port takes no no-op code.
  endfunction : word
  // One fabric cycle on both channels; idle cycles still carry random data.
  task automatic beat(input logic doCmd, input logic [7:0] c, input logic doWr);
    logic cRef, wRef;
    logic [255:0] r;
    cRef = cmdBufFull !== 1'b0 || calibComplete !== 1'b1;
    wRef = wrBufFull !== 1'b0 || calibComplete !== 1'b1;
    for (int i = 0; i < 8; i++) r[32*i+:32] = $random(seed);
    cmd = c;
    addr = r[79:0];
    bank = r[95:80];
    {wrData, wrMask} = r[255:96];
    cmdEn = doCmd;
    wrEn = doWr;
    for (int s = 0; s < N; s++)
      if (doCmd && !cRef && !inRst && !c[2*s+1])
        cmdQ.push_back({~c[2*s], r[s*AW+:AW], r[80+s*BW+:BW], 2'(s)});
    if (doWr && !wRef && !inRst) wrQ.push_back(r[255:96]);
    @(negedge clk);
    if (!inRst) chk("cmdDropped", doCmd && cRef, cmdDropped);
    if (!inRst) chk("wrDropped", doWr && wRef, wrDropped);
  endtask : beat
  task automatic drain(input string name);
    for (int i = 0; i < 300 && cmdQ.size() + wrQ.size() > 0; i++) beat(0, 8'h0, 0);
    chk("queues", 0, cmdQ.size() + wrQ.size());
    $display("test %s finished", name);
  endtask : drain
  // Scoreboard: every accepted transfer takes the oldest note.
  always @(posedge clk) begin
    if (memCmdValid === 1'b1 && memCmdReady === 1'b1) begin
      if (cmdQ.size() == 0) chk("spare slot", 0, 1);
      else chk("slot", cmdQ.pop_front(), slotSeen);
    end
    if (memWrValid === 1'b1 && memWrReady === 1'b1) begin
      if (wrQ.size() == 0) chk("spare beat", 0, 1);
      else chk("beat", wrQ.pop_front(), {memWrData, memWrMask});
    end
    cycles++;
    if (cycles == 6000) begin
      nMismatch++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] x;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("cmdBufEmpty", 1, cmdBufEmpty);
    chk("wrBufEmpty", 1, wrBufEmpty);
    // Long enough that the refusals are still seen once the checker is live.
    repeat (8) beat(1, 8'h55, 1);
    drain("uncalibrated");
    calibGo = 1'b1;
    stallAll = 1'b0;
    beat(0, 8'h0, 0);
    beat(0, 8'h0, 0);
    beat(1, 8'h65, 1);
    beat(1, 8'hae, 0);
    beat(1, 8'h00, 1);
    for (int i = 0; i < 40; i++) begin
      x = $random(seed);
      beat(x[5], word(x), x[6]);
    end
    drain("traffic");
    stallAll = 1'b1;
    repeat (7) beat(1, 8'h00, 1);
    chk("cmdBufFull", 1, cmdBufFull);
    chk("cmdBufAlmostFull", 1, cmdBufAlmostFull);
    chk("wrBufFull", 1, wrBufFull);
    chk("wrBufAlmostFull", 1, wrBufAlmostFull);
    stallAll = 1'b0;
    drain("fill");
    chk("cmdBufAlmostEmpty", 1, cmdBufAlmostEmpty);
    chk("wrBufAlmostEmpty", 1, wrBufAlmostEmpty);
    sysRst = 1'b1;
    inRst = 1'b1;
    // Two idle beats let the reset reach the buffers; earlier requests would still land.
    repeat (2) beat(0, 8'h0, 0);
    repeat (4) beat(1, 8'h55, 1);
    chk("cmdBufEmpty", 1, cmdBufEmpty);
    chk("memWrValid", 0, memWrValid);
    sysRst = 1'b0;
    repeat (6) beat(0, 8'h0, 0);
    inRst = 1'b0;
    beat(1, 8'hf5, 1);
    drain("primary reset");
    give_verdict();
  end
endmodule : dram_user_request_port_tb
bind dram_user_request_port dram_user_request_port_assertions
  dram_user_request_port_assertions_inst (.clk, .rst_n, .sysRst, .cmdEn, .cmd, .wrEn,
  .calibDoneIn, .memCmdReady, .memWrReady, .cmdBufEmpty, .cmdBufFull, .wrBufFull,
  .cmdDropped, .wrDropped, .calibComplete, .memCmdValid, .memCmdWrite, .memCmdSlot,
  .memWrValid, .memWrData);
`default_nettype wire

// *** tb/mem_side_model.sv ***
// Memory-side responder: ready handshakes with stalls, plus calibration done.
`timescale 1ns/1ns
`default_nettype none
module mem_side_model (
  // Clock and controls from the bench.
  input  wire logic clk,
  input  wire logic stallAll,
  input  wire logic calibGo,
  // Handshakes toward the port.
  output logic      memCmdReady,
  output logic      memWrReady,
  output logic      calibDoneIn
);
  // ************************************************************
  // Responder
  // ************************************************************
  integer seed = 32'hd659b5c0;
  // Ready drops at random one cycle in four so held outputs get exercised.
  always @(negedge clk) begin
    memCmdReady <= !stallAll && ($random(seed) % 4 != 0);
    memWrReady  <= !stallAll && ($random(seed) % 4 != 0);
    calibDoneIn <= calibGo;
  end
endmodule : mem_side_model
`default_nettype wire
